//--- verilog/sgcr_pkg.sv
// package: register map, field positions and reset values of the global control bank
package sgcr_pkg;
    localparam logic [7:0] SGCR_OFF_CTRL4 = 8'h06;
    localparam logic [7:0] SGCR_OFF_STORM_LOW = 8'h07;
    localparam logic [7:0] SGCR_OFF_TEST_A = 8'h08;
    localparam logic [7:0] SGCR_OFF_TEST_B = 8'h09;
    localparam logic [7:0] SGCR_OFF_TEST_C = 8'h0a;
    localparam logic [7:0] SGCR_OFF_HOST_CLK = 8'h0b;
    localparam logic [7:0] SGCR_OFF_PRIO_LOW = 8'h0c;
    localparam logic [7:0] SGCR_OFF_PRIO_HIGH = 8'h0d;
    localparam int SGCR_BIT_SPEED = 4;
    localparam int SGCR_BIT_NULLVID = 3;
    localparam int SGCR_POS_CLKSEL = 6;
    localparam logic [2:0] SGCR_RST_STORM_HIGH = 3'h0;
    localparam logic [7:0] SGCR_RST_STORM_LOW = 8'h63;
    localparam logic [7:0] SGCR_RST_TEST_A = 8'h00;
    localparam logic [7:0] SGCR_RST_TEST_B = 8'h24;
    localparam logic [7:0] SGCR_RST_TEST_C = 8'h35;
    localparam logic [5:0] SGCR_RST_CLK_LOW = 6'h08;
    localparam logic [7:0] SGCR_RST_PRIO_LOW = 8'h50;
    localparam logic [7:0] SGCR_RST_PRIO_HIGH = 8'hfa;
    localparam int SGCR_CLK_NS = 100;
    localparam int SGCR_PERIOD_FAST_MS = 67;
    localparam int SGCR_PERIOD_SLOW_MS = 500;
    localparam int SGCR_PERIOD_FAST_CYC = SGCR_PERIOD_FAST_MS * 1000000 / SGCR_CLK_NS;
    localparam int SGCR_PERIOD_SLOW_CYC = SGCR_PERIOD_SLOW_MS * 1000000 / SGCR_CLK_NS;
    typedef enum logic [1:0] {
        SGCR_CLK_31M = 2'b00,
        SGCR_CLK_62M = 2'b01,
        SGCR_CLK_125M = 2'b10
    } sgcr_clksel_t;
endpackage

//--- verilog/sgcr_regs.sv
// global control register bank with storm limiter and priority mapping
`timescale 1ns/1ps
`default_nettype none

module sgcr_regs
    import sgcr_pkg::*;
#(
    parameter int PERIOD_FAST_CYC = SGCR_PERIOD_FAST_CYC,
    parameter int PERIOD_SLOW_CYC = SGCR_PERIOD_SLOW_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic thirdPortSpeedStrap,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic [2:0] stormEnable,
    input wire logic [2:0] bcastBlock,
    output logic [2:0] bcastDrop,
    input wire logic frameValid,
    input wire logic frameTagged,
    input wire logic [2:0] frameTagPrio,
    input wire logic [11:0] frameVid,
    input wire logic [11:0] portDefaultVid,
    output logic [1:0] frameIntPrio,
    output logic [11:0] frameVidOut,
    output logic frameOutValid,
    output logic thirdPort10m,
    output logic nullVidReplace,
    output logic [1:0] hostClkSel
);
    typedef struct packed {
        logic speed;
        logic nullVid;
        logic [10:0] stormRate;
        logic [1:0] clkSel;
        logic [7:0] prioLow;
        logic [7:0] prioHigh;
        logic [7:0] rdata;
        logic rvalid;
        logic [22:0] periodCnt;
        logic [10:0] blkCnt0;
        logic [10:0] blkCnt1;
        logic [10:0] blkCnt2;
        logic [2:0] drop;
        logic [1:0] intPrio;
        logic [11:0] vidOut;
        logic outValid;
        logic strapDone;
    } sgcr_state_t;

    sgcr_state_t s_q, s_d;

    function automatic logic [1:0] sgcr_prio_lookup(input logic [15:0] map,
                                                    input logic [2:0] tag);
        sgcr_prio_lookup = map[{tag, 1'b0} +: 2];
    endfunction

    function automatic logic [10:0] sgcr_count(input logic [10:0] cnt, input logic en,
                                               input logic blk, input logic wrap);
        logic [10:0] base;
        // a block on the boundary cycle is the first of the new window, not a free pass
        base = wrap ? 11'h000 : cnt;
        if (!en) begin
            sgcr_count = 11'h000;
        end else if (blk && base != 11'h7ff) begin
            sgcr_count = base + 11'h001;
        end else begin
            sgcr_count = base;
        end
    endfunction

    logic [22:0] periodLen;
    logic periodWrap;
    logic [10:0] cnts [3];

    always_comb begin
        s_d = s_q;
        // 10 Mb/s runs the long window
        periodLen = s_q.speed ? 23'(PERIOD_SLOW_CYC - 1) : 23'(PERIOD_FAST_CYC - 1);
        periodWrap = (s_q.periodCnt >= periodLen);
        s_d.periodCnt = periodWrap ? 23'h000000 : s_q.periodCnt + 23'h000001;
        s_d.blkCnt0 = sgcr_count(s_q.blkCnt0, stormEnable[0], bcastBlock[0], periodWrap);
        s_d.blkCnt1 = sgcr_count(s_q.blkCnt1, stormEnable[1], bcastBlock[1], periodWrap);
        s_d.blkCnt2 = sgcr_count(s_q.blkCnt2, stormEnable[2], bcastBlock[2], periodWrap);
        cnts[0] = periodWrap ? 11'h000 : s_q.blkCnt0;
        cnts[1] = periodWrap ? 11'h000 : s_q.blkCnt1;
        cnts[2] = periodWrap ? 11'h000 : s_q.blkCnt2;
        for (int i = 0; i < 3; i++) begin
            // drop once the allowed count is used up in this window
            s_d.drop[i] = stormEnable[i] && bcastBlock[i]
                && (cnts[i] >= s_q.stormRate);
        end
        s_d.outValid = frameValid;
        s_d.intPrio = frameTagged ?
            sgcr_prio_lookup({s_q.prioHigh, s_q.prioLow}, frameTagPrio) : 2'b00;
        s_d.vidOut = (s_q.nullVid && frameVid == 12'h000) ? portDefaultVid : frameVid;
        // strap caught on the first edge after release, not under reset
        if (!s_q.strapDone) begin
            s_d.speed = thirdPortSpeedStrap;
            s_d.strapDone = 1'b1;
        end
        if (regWrite) begin
            if (regAddr == SGCR_OFF_CTRL4) begin
                s_d.speed = regWdata[SGCR_BIT_SPEED];
                s_d.nullVid = regWdata[SGCR_BIT_NULLVID];
                s_d.stormRate[10:8] = regWdata[2:0];
            end else if (regAddr == SGCR_OFF_STORM_LOW) begin
                s_d.stormRate[7:0] = regWdata;
            end else if (regAddr == SGCR_OFF_HOST_CLK) begin
                s_d.clkSel = regWdata[SGCR_POS_CLKSEL +: 2];
            end else if (regAddr == SGCR_OFF_PRIO_LOW) begin
                s_d.prioLow = regWdata;
            end else if (regAddr == SGCR_OFF_PRIO_HIGH) begin
                s_d.prioHigh = regWdata;
            end
            // test registers and reserved bits take no write
        end
        s_d.rvalid = regRead;
        s_d.rdata = 8'h00;
        if (regRead) begin
            if (regAddr == SGCR_OFF_CTRL4) begin
                s_d.rdata = {3'h0, s_q.speed, s_q.nullVid, s_q.stormRate[10:8]};
            end else if (regAddr == SGCR_OFF_STORM_LOW) begin
                s_d.rdata = s_q.stormRate[7:0];
            end else if (regAddr == SGCR_OFF_TEST_A) begin
                s_d.rdata = SGCR_RST_TEST_A;
            end else if (regAddr == SGCR_OFF_TEST_B) begin
                s_d.rdata = SGCR_RST_TEST_B;
            end else if (regAddr == SGCR_OFF_TEST_C) begin
                s_d.rdata = SGCR_RST_TEST_C;
            end else if (regAddr == SGCR_OFF_HOST_CLK) begin
                s_d.rdata = {s_q.clkSel, SGCR_RST_CLK_LOW};
            end else if (regAddr == SGCR_OFF_PRIO_LOW) begin
                s_d.rdata = s_q.prioLow;
            end else if (regAddr == SGCR_OFF_PRIO_HIGH) begin
                s_d.rdata = s_q.prioHigh;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.stormRate <= {SGCR_RST_STORM_HIGH, SGCR_RST_STORM_LOW};
            s_q.clkSel <= SGCR_CLK_125M;
            s_q.prioLow <= SGCR_RST_PRIO_LOW;
            s_q.prioHigh <= SGCR_RST_PRIO_HIGH;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign regRvalid = s_q.rvalid;
    assign bcastDrop = s_q.drop;
    assign frameIntPrio = s_q.intPrio;
    assign frameVidOut = s_q.vidOut;
    assign frameOutValid = s_q.outValid;
    assign thirdPort10m = s_q.speed;
    assign nullVidReplace = s_q.nullVid;
    assign hostClkSel = s_q.clkSel;

    property p_strap;
        @(posedge sys_clk) disable iff (!reset_n)
        !$past(reset_n) && !regWrite |=> thirdPort10m == $past(thirdPortSpeedStrap);
    endproperty
    a_strap: assert property (p_strap) else $error("speed strap not loaded");

    property p_speed_wr;
        @(posedge sys_clk) disable iff (!reset_n)
        regWrite && regAddr == SGCR_OFF_CTRL4 && s_q.strapDone
            |=> thirdPort10m == $past(regWdata[4]) && nullVidReplace == $past(regWdata[3]);
    endproperty
    a_speed_wr: assert property (p_speed_wr) else $error("ctrl4 write lost");

    property p_nullvid;
        @(posedge sys_clk) disable iff (!reset_n)
        frameValid && nullVidReplace && frameVid == 12'h000 |=> frameVidOut == $past(portDefaultVid);
    endproperty
    a_nullvid: assert property (p_nullvid) else $error("null vid not replaced");

    property p_novid;
        @(posedge sys_clk) disable iff (!reset_n)
        frameValid && !nullVidReplace |=> frameVidOut == $past(frameVid);
    endproperty
    a_novid: assert property (p_novid) else $error("vid changed when off");

    property p_test_rd;
        @(posedge sys_clk) disable iff (!reset_n)
        regRead && regAddr == SGCR_OFF_TEST_B |=> regRvalid && regRdata == 8'h24;
    endproperty
    a_test_rd: assert property (p_test_rd) else $error("test register value wrong");

    property p_clk_rd;
        @(posedge sys_clk) disable iff (!reset_n)
        regRead && regAddr == SGCR_OFF_HOST_CLK |=> regRdata[5:0] == 6'h08;
    endproperty
    a_clk_rd: assert property (p_clk_rd) else $error("reserved bits wrong");

    property p_clk_rst;
        @(posedge sys_clk) !reset_n |=> hostClkSel == 2'b10;
    endproperty
    a_clk_rst: assert property (p_clk_rst) else $error("clock select reset wrong");

    property p_storm_rst;
        @(posedge sys_clk) !reset_n |=> s_q.stormRate == 11'h063 && s_q.prioHigh == 8'hfa;
    endproperty
    a_storm_rst: assert property (p_storm_rst) else $error("reset values wrong");

    property p_prio;
        @(posedge sys_clk) disable iff (!reset_n)
        frameValid && frameTagged && frameTagPrio == 3'h5 && !regWrite
            |=> frameIntPrio == $past(s_q.prioHigh[3:2]);
    endproperty
    a_prio: assert property (p_prio) else $error("priority map wrong");

    property p_nodrop;
        @(posedge sys_clk) disable iff (!reset_n)
        !stormEnable[0] |=> !bcastDrop[0];
    endproperty
    a_nodrop: assert property (p_nodrop) else $error("drop on disabled port");

    property p_wrap;
        @(posedge sys_clk) disable iff (!reset_n)
        periodWrap |=> s_q.periodCnt == 23'h000000
            && s_q.blkCnt0 == {10'h000, $past(stormEnable[0] && bcastBlock[0])};
    endproperty
    a_wrap: assert property (p_wrap) else $error("period restart missed");

    property p_untagged;
        @(posedge sys_clk) disable iff (!reset_n)
        frameValid && !frameTagged |=> frameIntPrio == 2'b00;
    endproperty
    a_untagged: assert property (p_untagged) else $error("untagged got priority");

    property p_prio_low;
        @(posedge sys_clk) disable iff (!reset_n)
        frameValid && frameTagged && frameTagPrio == 3'h2
            |=> frameIntPrio == $past(s_q.prioLow[5:4]);
    endproperty
    a_prio_low: assert property (p_prio_low) else $error("low map field wrong");

    property p_drop_thr;
        @(posedge sys_clk) disable iff (!reset_n)
        stormEnable[0] && bcastBlock[0] && !periodWrap && s_q.blkCnt0 >= s_q.stormRate
            |=> bcastDrop[0];
    endproperty
    a_drop_thr: assert property (p_drop_thr) else $error("over threshold passed");

    property p_pass_wrap;
        @(posedge sys_clk) disable iff (!reset_n)
        stormEnable[0] && bcastBlock[0] && periodWrap && s_q.stormRate != 11'h000
            |=> !bcastDrop[0];
    endproperty
    a_pass_wrap: assert property (p_pass_wrap) else $error("first block dropped");

    property p_clk_wr;
        @(posedge sys_clk) disable iff (!reset_n)
        regWrite && regAddr == SGCR_OFF_HOST_CLK |=> hostClkSel == $past(regWdata[7:6]);
    endproperty
    a_clk_wr: assert property (p_clk_wr) else $error("clock select write lost");

    property p_storm_wr;
        @(posedge sys_clk) disable iff (!reset_n)
        regWrite && regAddr == SGCR_OFF_STORM_LOW |=> s_q.stormRate[7:0] == $past(regWdata);
    endproperty
    a_storm_wr: assert property (p_storm_wr) else $error("storm low write lost");

    property p_test_c;
        @(posedge sys_clk) disable iff (!reset_n)
        regRead && regAddr == SGCR_OFF_TEST_C |=> regRvalid && regRdata == 8'h35;
    endproperty
    a_test_c: assert property (p_test_c) else $error("third test register wrong");

    property p_period_max;
        @(posedge sys_clk) disable iff (!reset_n)
        s_q.periodCnt <= 23'(PERIOD_SLOW_CYC - 1);
    endproperty
    a_period_max: assert property (p_period_max) else $error("window overran");

    c_drop: cover property (@(posedge sys_clk) disable iff (!reset_n) bcastDrop[0]);
    c_wr: cover property (@(posedge sys_clk) disable iff (!reset_n)
        regWrite && regAddr == SGCR_OFF_PRIO_HIGH);
    c_vid: cover property (@(posedge sys_clk) disable iff (!reset_n)
        frameValid && nullVidReplace && frameVid == 12'h000);
    c_wrap: cover property (@(posedge sys_clk) disable iff (!reset_n) periodWrap);
    c_slow: cover property (@(posedge sys_clk) disable iff (!reset_n) periodWrap && thirdPort10m);
endmodule
`default_nettype wire

//--- bench/sgcr_regs_tb.sv
// self-checking bench for the global control register bank
`timescale 1ns/1ps
`default_nettype none
module sgcr_regs_tb
    import sgcr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic thirdPortSpeedStrap = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic regRvalid;
    logic [2:0] stormEnable = 3'h0;
    logic [2:0] bcastBlock = 3'h0;
    logic [2:0] bcastDrop;
    logic frameValid = 1'b0;
    logic frameTagged = 1'b0;
    logic [2:0] frameTagPrio = 3'h0;
    logic [11:0] frameVid = 12'h000;
    logic [11:0] portDefaultVid = 12'h000;
    logic [1:0] frameIntPrio;
    logic [11:0] frameVidOut;
    logic frameOutValid;
    logic thirdPort10m;
    logic nullVidReplace;
    logic [1:0] hostClkSel;
    logic [199:0] drops;
    logic [199:0] drops2;
    logic [7:0] rstVal [8] = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88, 8'h50, 8'hfa};
    int n_mismatch = 0;
    int n_tests = 0;

    always #50 sys_clk = ~sys_clk;

    // short periods so a few storm windows fit in the run
    sgcr_regs #(.PERIOD_FAST_CYC(20), .PERIOD_SLOW_CYC(50)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .thirdPortSpeedStrap(thirdPortSpeedStrap),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRvalid(regRvalid), .stormEnable(stormEnable),
        .bcastBlock(bcastBlock), .bcastDrop(bcastDrop), .frameValid(frameValid),
        .frameTagged(frameTagged), .frameTagPrio(frameTagPrio), .frameVid(frameVid),
        .portDefaultVid(portDefaultVid), .frameIntPrio(frameIntPrio),
        .frameVidOut(frameVidOut), .frameOutValid(frameOutValid),
        .thirdPort10m(thirdPort10m), .nullVidReplace(nullVidReplace), .hostClkSel(hostClkSel)
    );

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    // answer stands one cycle only, so look right after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        chk({11'h0, regRvalid}, 12'h001);
        chk({4'h0, regRdata}, {4'h0, exp});
    endtask

    task automatic frm(input logic tg, input logic [2:0] p, input logic [11:0] vid,
                       input logic [1:0] expP, input logic [11:0] expV);
        @(posedge sys_clk);
        frameValid <= 1'b1;
        frameTagged <= tg;
        frameTagPrio <= p;
        frameVid <= vid;
        portDefaultVid <= 12'h123;
        @(posedge sys_clk);
        frameValid <= 1'b0;
        #1;
        chk({11'h0, frameOutValid}, 12'h001);
        chk({10'h0, frameIntPrio}, {10'h0, expP});
        chk(frameVidOut, expV);
    endtask

    // period phase is unknown, so sync on the first pass after a drop run
    task automatic storm(input int per);
        int first = -1;
        @(posedge sys_clk);
        stormEnable <= 3'b101;
        bcastBlock <= 3'b111;
        for (int i = 0; i < 200; i++) begin
            @(posedge sys_clk);
            #1;
            drops[i] = bcastDrop[0];
            drops2[i] = bcastDrop[2];
            chk({11'h0, bcastDrop[1]}, 12'h000);
        end
        @(posedge sys_clk);
        bcastBlock <= 3'h0;
        stormEnable <= 3'h0;
        for (int i = 1; i < 100; i++)
            if (first < 0 && drops[i - 1] && !drops[i]) first = i;
        chk({11'h0, first >= 0}, 12'h001);
        for (int j = 0; j < 2 * per && first >= 0; j++) begin
            chk({11'h0, drops[first + j]}, {11'h0, (j % per) >= 3});
            chk({11'h0, drops2[first + j]}, {11'h0, (j % per) >= 3});
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 8; k++)
            rd(SGCR_OFF_CTRL4 + 8'(k), rstVal[k]);
        chk({10'h0, hostClkSel}, 12'h002);
        chk({11'h0, thirdPort10m}, 12'h000);
        for (int p = 0; p < 8; p++)
            frm(1'b1, 3'(p), 12'h456, 2'(p / 2), 12'h456);
        frm(1'b1, 3'h0, 12'h000, 2'h0, 12'h000);
        frm(1'b0, 3'h7, 12'h456, 2'h0, 12'h456);
        for (int k = 2; k < 5; k++) begin
            wr(SGCR_OFF_CTRL4 + 8'(k), 8'hff);
            rd(SGCR_OFF_CTRL4 + 8'(k), rstVal[k]);
        end
        // reserved low bits must keep reading 0x08 whatever is written
        for (int c = 0; c < 3; c++) begin
            // no serial host clock runs in this bench, so every code is in range
            wr(SGCR_OFF_HOST_CLK, {2'(c), 6'h3f});
            rd(SGCR_OFF_HOST_CLK, {2'(c), 6'h08});
            chk({10'h0, hostClkSel}, 12'(c));
        end
        wr(SGCR_OFF_CTRL4, 8'hff);
        rd(SGCR_OFF_CTRL4, 8'h1f);
        chk({10'h0, thirdPort10m, nullVidReplace}, 12'h003);
        frm(1'b1, 3'h0, 12'h000, 2'h0, 12'h123);
        frm(1'b1, 3'h0, 12'h456, 2'h0, 12'h456);
        wr(SGCR_OFF_PRIO_LOW, 8'he4);
        wr(SGCR_OFF_PRIO_HIGH, 8'h1b);
        for (int p = 0; p < 8; p++)
            frm(1'b1, 3'(p), 12'h456, p < 4 ? 2'(p) : 2'(7 - p), 12'h456);
        wr(SGCR_OFF_CTRL4, 8'h00);
        wr(SGCR_OFF_STORM_LOW, 8'h03);
        chk({11'h0, thirdPort10m}, 12'h000);
        storm(20);
        wr(SGCR_OFF_CTRL4, 8'h10);
        storm(50);
        thirdPortSpeedStrap <= 1'b1;
        reset_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({11'h0, thirdPort10m}, 12'h001);
        rd(SGCR_OFF_CTRL4, 8'h10);
        results();
    end
endmodule
`default_nettype wire
